// [sim/ppo_channel_bench.sv]
// self-checking bench for the pulse parameter output channel
`default_nettype none
module ppo_channel_bench
   import ppo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 8;
   localparam int P_DSK = 0, P_CLR = 1, P_GO = 2, P_STOP = 3, P_SUSP = 4, P_RES = 5;
   logic clk_i, rstn_i, word_clk, role_timing_i, wr_valid_i, wr_ready_o, start_i, stop_i, suspend_i, resume_i;
   logic deskew_cmd_i, underrun_clr_i, lnk_clk_o, lnk_en_o, lnk_valid_o, running_o, underrun_o;
   logic deskew_busy_o, deskew_needed_o;
   logic [5:0] ctl;
   logic [1:0] dev_set, dev_type, role_o, dev_type_o;
   logic [WORD_W-1:0] wr_data_i, pulse_o, rx_word;
   logic [DELAY_W-1:0] delay_i;
   logic [ICB_W-1:0] icb_i, icb_o;
   logic [LANES-1:0] lane_o;
   logic [GRAD_ADDR_W-1:0] grad_addr_o;
   logic [15:0] rx_cnt, bal_err;
   int errors = 0;
   int total_checks = 0;
   // single-cycle controls share one vector
   assign {resume_i, suspend_i, stop_i, start_i, underrun_clr_i, deskew_cmd_i} = ctl;
   ppo_channel #(.DEPTH(4)) u_dut (.clk_i, .rstn_i, .word_clk_i(word_clk), .dev_type_i(dev_type), .role_timing_i,
      .wr_valid_i, .wr_data_i, .wr_ready_o, .start_i, .stop_i, .suspend_i, .resume_i, .delay_i, .deskew_cmd_i,
      .underrun_clr_i, .icb_i, .icb_o, .lane_o, .lnk_clk_o, .lnk_en_o, .lnk_valid_o, .pulse_o, .grad_addr_o,
      .role_o, .dev_type_o, .running_o, .underrun_o, .deskew_busy_o, .deskew_needed_o);
   ppo_link_rx u_far (.clk_i, .lane_i(lane_o), .lnk_clk_i(lnk_clk_o), .lnk_valid_i(lnk_valid_o), .dev_set_i(dev_set),
      .word_clk_o(word_clk), .dev_type_o(dev_type), .rx_word_o(rx_word), .rx_cnt_o(rx_cnt), .bal_err_o(bal_err));
   // 25 MHz system clock
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   task automatic check(input string what, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // a wait that ran out ends the run
   task automatic guard(input string what, input logic ok);
      check(what, WORD_W'(ok), WORD_W'(1));
      if (ok !== 1'b1)
         finish_test();
   endtask
   function automatic logic [WORD_W-1:0] gword(input int k);
      return {GRAD_ADDR_W'(k + 1), 6'(k), 32'h9e37_79b9 ^ 32'(k * 7)};
   endfunction
   task automatic pulse(input int b);
      @(posedge clk_i);
      ctl[b] <= 1'b1;
      @(posedge clk_i);
      ctl[b] <= 1'b0;
   endtask
   task automatic fill(input int n);
      for (int k = 0; k < n; k++)
      begin
         @(posedge clk_i);
         wr_valid_i <= 1'b1;
         wr_data_i <= gword(k);
      end
      @(posedge clk_i);
      wr_valid_i <= 1'b0;
   endtask
   task automatic settle(input logic [1:0] d, input logic [ICB_W-1:0] b);
      @(posedge clk_i);
      dev_set <= d;
      icb_i <= b;
      repeat (6) @(negedge clk_i);
   endtask
   task automatic t_status();
      for (int c = 0; c < 4; c++)
      begin
         settle(2'(c), 3'h0);
         check("device", WORD_W'(dev_type_o), WORD_W'(c));
      end
      settle(DEV_GRAD_AMP, 3'h4);
      check("role", WORD_W'(role_o), WORD_W'(ROLE_FREQ));
      settle(DEV_GRAD_AMP, 3'h0);
      check("role", WORD_W'(role_o), WORD_W'(ROLE_GRAD));
      check("icb grad", WORD_W'(icb_o[ICB_GRAD]), WORD_W'(1));
   endtask
   task automatic t_deskew();
      int n;
      pulse(P_DSK);
      @(negedge clk_i);
      check("busy", WORD_W'(deskew_busy_o), WORD_W'(1));
      check("needed", WORD_W'(deskew_needed_o), WORD_W'(0));
      for (n = 0; n < 400 && deskew_busy_o === 1'b1; n++) @(negedge clk_i);
      guard("deskew end", deskew_busy_o === 1'b0);
      check("deskew long", WORD_W'(n >= 15 * TICK), WORD_W'(1));
      check("no data", WORD_W'(rx_cnt), WORD_W'(0));
      settle(DEV_NONE, 3'h0);
      settle(DEV_GRAD_AMP, 3'h0);
      check("needed", WORD_W'(deskew_needed_o), WORD_W'(1));
   endtask
   task automatic t_grad_run();
      int n;
      fill(5);
      @(negedge clk_i);
      check("full", WORD_W'(wr_ready_o), WORD_W'(0));
      @(posedge clk_i);
      delay_i <= 30'h2;
      icb_i <= 3'h1;
      for (n = 0; n < 200 && grad_addr_o === '0; n++) @(negedge clk_i);
      guard("addr wait", grad_addr_o !== '0);
      check("addr", WORD_W'(grad_addr_o), gword(0) >> GRAD_ADDR_LSB);
      check("active", WORD_W'(icb_o[ICB_RUN] & running_o), WORD_W'(1));
      for (int k = 0; k < 4; k++)
      begin
         for (n = 0; n < 100 && rx_cnt !== 16'(k + 1); n++) @(negedge clk_i);
         guard("word wait", rx_cnt === 16'(k + 1));
         check("word", rx_word, gword(k));
      end
      for (n = 0; n < 100 && underrun_o !== 1'b1; n++) @(negedge clk_i);
      guard("underrun", underrun_o === 1'b1);
      repeat (2 * TICK) @(negedge clk_i);
      check("held", rx_word, gword(3));
      check("held addr", WORD_W'(grad_addr_o), gword(3) >> GRAD_ADDR_LSB);
      check("balance", WORD_W'(bal_err), WORD_W'(0));
      @(posedge clk_i);
      icb_i <= 3'h0;
      pulse(P_CLR);
      repeat (2) @(negedge clk_i);
      check("cleared", WORD_W'(underrun_o | running_o), WORD_W'(0));
   endtask
   task automatic t_timing();
      int n;
      @(posedge clk_i);
      role_timing_i <= 1'b1;
      repeat (6) @(negedge clk_i);
      check("role", WORD_W'(role_o), WORD_W'(ROLE_TIMING));
      fill(3);
      pulse(P_GO);
      for (n = 0; n < 200 && pulse_o !== gword(0); n++) @(negedge clk_i);
      guard("pulse word", pulse_o === gword(0));
      for (n = 0; n < 100 && pulse_o === gword(0); n++) @(negedge clk_i);
      guard("hold end", pulse_o !== gword(0));
      check("hold", WORD_W'(n >= MIN_HOLD_WORDS * TICK - 1), WORD_W'(1));
      check("next", pulse_o, gword(1));
      check("link idle", WORD_W'(lnk_valid_o), WORD_W'(0));
      pulse(P_SUSP);
      repeat (2) @(negedge clk_i);
      check("suspend", WORD_W'({icb_o[ICB_SUSPEND], running_o}), WORD_W'(2));
      pulse(P_RES);
      repeat (2) @(negedge clk_i);
      check("resume", WORD_W'(running_o), WORD_W'(1));
      pulse(P_STOP);
      repeat (2) @(negedge clk_i);
      check("stop", WORD_W'(icb_o[ICB_RUN]), WORD_W'(0));
   endtask
   // reset, then the scenarios in turn
   initial
   begin
      {ctl, dev_set, role_timing_i, wr_valid_i, wr_data_i, delay_i, icb_i} = '0;
      rstn_i = 1'b0;
      repeat (16) @(posedge clk_i);
      check("needed", WORD_W'(deskew_needed_o), WORD_W'(1));
      check("ready", WORD_W'(wr_ready_o), WORD_W'(1));
      rstn_i <= 1'b1;
      repeat (2) @(negedge clk_i);
      check("link on", WORD_W'(lnk_en_o), WORD_W'(1));
      t_status();
      t_deskew();
      t_grad_run();
      t_timing();
      finish_test();
   end
endmodule
`default_nettype wire

// [sim/ppo_link_rx.sv]
// far-end link model: word pace, status lines, lane deserializer
`default_nettype none
module ppo_link_rx
   import ppo_pkg::*;
(
   input wire logic clk_i,
   input wire logic [LANES-1:0] lane_i,
   input wire logic lnk_clk_i,
   input wire logic lnk_valid_i,
   input wire logic [1:0] dev_set_i,
   output logic word_clk_o,
   output logic [1:0] dev_type_o,
   output logic [WORD_W-1:0] rx_word_o,
   output logic [15:0] rx_cnt_o,
   output logic [15:0] bal_err_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [SLOT_BITS-1:0] sh [LANES];
   logic [WORD_W-1:0] word_c;
   logic bad_c;
   logic prev_clk = 1'b0;
   logic valid_seen = 1'b0;
   int slot = 0;
   // attached device reports its kind
   assign dev_type_o = dev_set_i;
   // word pace with phase unrelated to clk_i
   initial
   begin
      {rx_word_o, rx_cnt_o, bal_err_o} = '0;
      word_clk_o = 1'b0;
      #7;
      forever #160 word_clk_o = ~word_clk_o;
   end
   // rebuild the word, test each balance bit
   always_comb
   begin
      bad_c = 1'b0;
      for (int l = 0; l < LANES; l++)
      begin
         word_c[l*LANE_BITS +: LANE_BITS] = sh[l][LANE_BITS-1:0];
         bad_c = bad_c | (sh[l][LANE_BITS] !== ~^sh[l][LANE_BITS-1:0]);
      end
   end
   // seven slots per lane after each forwarded clock rise
   always @(posedge clk_i)
   begin
      prev_clk <= lnk_clk_i;
      if (lnk_clk_i && !prev_clk)
      begin
         slot <= 1;
         valid_seen <= lnk_valid_i;
         for (int l = 0; l < LANES; l++)
            sh[l][0] <= lane_i[l];
      end
      else if (slot > 0 && slot < SLOT_BITS)
      begin
         for (int l = 0; l < LANES; l++)
            sh[l][slot] <= lane_i[l];
         slot <= slot + 1;
      end
      else if (slot == SLOT_BITS)
      begin
         slot <= 0;
         bal_err_o <= bal_err_o + 16'(bad_c);
         if (valid_seen)
         begin
            rx_word_o <= word_c;
            rx_cnt_o <= rx_cnt_o + 16'h1;
         end
      end
   end
endmodule
`default_nettype wire

// [verilog/ppo_channel.sv]
// transmit channel: parameter fifo, sequencer, role select and lane serializer
`default_nettype none

// parameterised word fifo with valid/ready on both sides
module ppo_fifo
   import ppo_pkg::*;
#(
   parameter int W = WORD_W,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [AW:0] cnt_reg;
   logic [AW:0] cnt_next;
   logic push;
   logic pop;
   logic ready_reg;

   // handshake decode
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign in_ready_o = ready_reg; // space flag straight from a flop
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem_reg[rptr_reg];
   assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

   // storage write
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_reg[wptr_reg] <= in_data_i;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg <= '0;
         ready_reg <= 1'b1;
      end
      else
      begin
         wptr_reg <= push ? AW'((wptr_reg + 1) % DEPTH) : wptr_reg;
         rptr_reg <= pop ? AW'((rptr_reg + 1) % DEPTH) : rptr_reg;
         cnt_reg <= cnt_next;
         ready_reg <= (cnt_next != (AW+1)'(DEPTH));
      end
   end
endmodule

// Notes on behaviour
// R1: one 48-bit word leaves per channel word clock cycle.
// R2: frequency set is two consecutive words; gradient setting one word.
// R3: a new parameter word may take effect on any word cycle.
// R4: in pulse role each word holds at least two word cycles.
// R5: gradient words carry a 10-bit channel address, 1k channels.
// R6: programmable start delay up to two to the 29th word cycles.
// R7: inter-channel bus exchanges run, suspend, gradient state every cycle.
// R8: processor fills fifo; running sequencer drains it at word pace.
// R9: start, stop, suspend, resume act only through the timing channel.
// R10: timing role drives pulse outputs; link then carries no valid data.
// R11: each word serialized over 8 lanes with forwarded clock.
// R12: each lane sends 6 payload bits plus one balance bit.
// R13: far end deserializes lanes and rebuilds word and word clock.
// R14: link driver stays enabled always, even without valid data; code holds lnk_en_o low during reset.
// R15: deskew runs only on command; receiver enables it separately.
// R16: deskew needed again after power-up and every reconnect.
// R17: two status lines report the attached device type.
// R18: word pacing follows the sampled word clock, up to receiver rate.
// R19: gradient role only with gradient amplifier and no other gradient channel.
// R20: status codes 00 none, 01 freq, 10 grad, 11 preemph; synced twice.
// R21: fifo empty while running holds last word, sets sticky underrun.
module ppo_channel
   import ppo_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic word_clk_i,
   input wire logic [1:0] dev_type_i,
   input wire logic role_timing_i,
   input wire logic wr_valid_i,
   input wire logic [WORD_W-1:0] wr_data_i,
   output logic wr_ready_o,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic suspend_i,
   input wire logic resume_i,
   input wire logic [DELAY_W-1:0] delay_i,
   input wire logic deskew_cmd_i,
   input wire logic underrun_clr_i,
   input wire logic [ICB_W-1:0] icb_i,
   output logic [ICB_W-1:0] icb_o,
   output logic [LANES-1:0] lane_o,
   output logic lnk_clk_o,
   output logic lnk_en_o,
   output logic lnk_valid_o,
   output logic [WORD_W-1:0] pulse_o,
   output logic [GRAD_ADDR_W-1:0] grad_addr_o,
   output logic [1:0] role_o,
   output logic [1:0] dev_type_o,
   output logic running_o,
   output logic underrun_o,
   output logic deskew_busy_o,
   output logic deskew_needed_o
);
   // balance bit gives each lane slot an odd count of ones
   function automatic logic balance(input logic [LANE_BITS-1:0] bits);
      return ~(^bits);
   endfunction

   // synchronisers for pins from outside the clock domain
   logic wclk_s1_reg;
   logic wclk_s2_reg;
   logic wclk_d_reg;
   logic [1:0] dev_s1_reg;
   logic [1:0] dev_s2_reg;
   logic [1:0] dev_d_reg;
   logic tim_s1_reg;
   logic tim_s2_reg;
   ppo_role_type role_reg;
   ppo_role_type role_next;
   ppo_state_type state_reg;
   ppo_state_type state_next;
   logic [DELAY_W-1:0] dly_cnt_reg;
   logic [1:0] hold_cnt_reg;
   logic [WORD_W-1:0] cur_word_reg;
   logic [SLOT_BITS-1:0] sreg_reg [LANES];
   logic [2:0] bit_cnt_reg;
   logic [4:0] dsk_cnt_reg;
   logic dsk_word_reg;
   logic pop_valid_reg;
   logic tick;
   logic fifo_valid;
   logic [WORD_W-1:0] fifo_data;
   logic pop;
   logic hold_ok;
   logic run_cmd;
   logic stop_cmd;
   logic susp_cmd;
   logic res_cmd;
   logic starve;
   logic reconnect;
   logic deskew_go;
   logic [WORD_W-1:0] tx_word;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wclk_s1_reg <= 1'b0;
         wclk_s2_reg <= 1'b0;
         wclk_d_reg <= 1'b0;
         dev_s1_reg <= DEV_NONE;
         dev_s2_reg <= DEV_NONE;
         dev_d_reg <= DEV_NONE;
         tim_s1_reg <= 1'b0;
         tim_s2_reg <= 1'b0;
      end
      else
      begin
         wclk_s1_reg <= word_clk_i;
         wclk_s2_reg <= wclk_s1_reg;
         wclk_d_reg <= wclk_s2_reg;
         dev_s1_reg <= dev_type_i;
         dev_s2_reg <= dev_s1_reg; // R20
         dev_d_reg <= dev_s2_reg;
         tim_s1_reg <= role_timing_i;
         tim_s2_reg <= tim_s1_reg;
      end
   end

   // word tick, acquisition commands and role choice
   assign tick = wclk_s2_reg && !wclk_d_reg; // R1 R18
   assign run_cmd = (role_reg == ROLE_TIMING) ? start_i : icb_i[ICB_RUN]; // R9
   assign stop_cmd = (role_reg == ROLE_TIMING) ? stop_i : !icb_i[ICB_RUN]; // R9
   assign susp_cmd = (role_reg == ROLE_TIMING) ? suspend_i : icb_i[ICB_SUSPEND];
   assign res_cmd = (role_reg == ROLE_TIMING) ? resume_i : !icb_i[ICB_SUSPEND];
   assign role_next = tim_s2_reg ? ROLE_TIMING :
      ((dev_s2_reg == DEV_GRAD_AMP) && (role_reg == ROLE_GRAD || !icb_i[ICB_GRAD])) ? ROLE_GRAD : // R19
      ROLE_FREQ;
   assign hold_ok = (role_reg != ROLE_TIMING) || (hold_cnt_reg == 2'h0); // R4
   assign pop = tick && (state_reg == ST_RUN) && fifo_valid && hold_ok; // R3 R8
   assign starve = tick && (state_reg == ST_RUN) && !fifo_valid && hold_ok; // R21
   assign reconnect = (dev_d_reg == DEV_NONE) && (dev_s2_reg != DEV_NONE); // R16
   assign deskew_go = deskew_cmd_i && !deskew_busy_o; // R15
   assign tx_word = dsk_word_reg ? DESKEW_PATTERN :
      (role_reg == ROLE_TIMING || !pop_valid_reg) ? IDLE_WORD : cur_word_reg; // R10

   // sequencer next state
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: if (run_cmd) state_next = ST_DELAY;
         ST_DELAY: if (stop_cmd) state_next = ST_IDLE;
            else if (tick && dly_cnt_reg == '0) state_next = ST_RUN; // R6
         ST_RUN: if (stop_cmd) state_next = ST_IDLE;
            else if (susp_cmd) state_next = ST_SUSP;
         ST_SUSP: if (stop_cmd) state_next = ST_IDLE;
            else if (res_cmd) state_next = ST_RUN;
      endcase
   end

   ppo_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_fifo
   (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .in_valid_i(wr_valid_i),
      .in_data_i(wr_data_i),
      .in_ready_o(wr_ready_o),
      .out_valid_o(fifo_valid),
      .out_data_o(fifo_data),
      .out_ready_i(pop)
   );

   // sequencer, delay, hold and word registers
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         role_reg <= ROLE_FREQ;
         state_reg <= ST_IDLE;
         dly_cnt_reg <= '0;
         hold_cnt_reg <= 2'h0;
         cur_word_reg <= IDLE_WORD;
         pop_valid_reg <= 1'b0;
         underrun_o <= 1'b0;
      end
      else
      begin
         role_reg <= (state_reg == ST_IDLE) ? role_next : role_reg;
         state_reg <= state_next;
         dly_cnt_reg <= (state_reg == ST_IDLE) ? delay_i :
            (tick && dly_cnt_reg != '0) ? dly_cnt_reg - 1'b1 : dly_cnt_reg; // R6
         hold_cnt_reg <= pop ? 2'(MIN_HOLD_WORDS - 1) :
            (tick && hold_cnt_reg != 2'h0) ? hold_cnt_reg - 2'h1 : hold_cnt_reg; // R4
         cur_word_reg <= pop ? fifo_data : cur_word_reg; // R2 R21
         pop_valid_reg <= tick ? pop : pop_valid_reg;
         underrun_o <= starve || (underrun_o && !underrun_clr_i); // R21
      end
   end

   // deskew request and training run
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         dsk_cnt_reg <= '0;
         dsk_word_reg <= 1'b0;
         deskew_busy_o <= 1'b0;
         deskew_needed_o <= 1'b1;
      end
      else
      begin
         deskew_busy_o <= deskew_go || (deskew_busy_o && !(tick && dsk_cnt_reg == 5'h1)); // R15
         dsk_cnt_reg <= deskew_go ? 5'(DESKEW_WORDS) : (tick && dsk_cnt_reg != '0) ? dsk_cnt_reg - 5'h1 : dsk_cnt_reg;
         dsk_word_reg <= tick ? deskew_busy_o : dsk_word_reg;
         deskew_needed_o <= reconnect || (deskew_needed_o && !deskew_go); // R16
      end
   end

   // lane serializer and forwarded clock
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         for (int l = 0; l < LANES; l++) sreg_reg[l] <= '0;
         bit_cnt_reg <= 3'(SLOT_BITS);
         lane_o <= '0;
         lnk_clk_o <= 1'b0;
         lnk_en_o <= 1'b0;
         lnk_valid_o <= 1'b0;
      end
      else
      begin
         for (int l = 0; l < LANES; l++)
         begin
            sreg_reg[l] <= tick ? {balance(tx_word[l*LANE_BITS +: LANE_BITS]), tx_word[l*LANE_BITS +: LANE_BITS]} :
               (sreg_reg[l] >> 1); // R11 R12
            lane_o[l] <= sreg_reg[l][0];
         end
         bit_cnt_reg <= tick ? 3'h0 : (bit_cnt_reg != 3'(SLOT_BITS)) ? bit_cnt_reg + 3'h1 : bit_cnt_reg;
         lnk_clk_o <= (bit_cnt_reg < 3'(FWD_HIGH_SLOTS)); // R11
         lnk_en_o <= 1'b1; // R14
         lnk_valid_o <= tick ? (pop_valid_reg && role_reg != ROLE_TIMING && !dsk_word_reg) : lnk_valid_o; // R10
      end
   end

   // pulse outputs, bus exchange and status
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pulse_o <= '0;
         grad_addr_o <= '0;
         icb_o <= '0;
         role_o <= ROLE_FREQ;
         dev_type_o <= DEV_NONE;
         running_o <= 1'b0;
      end
      else
      begin
         pulse_o <= (role_reg == ROLE_TIMING) ? cur_word_reg : '0; // R10
         grad_addr_o <= (role_reg == ROLE_GRAD) ? cur_word_reg[GRAD_ADDR_LSB +: GRAD_ADDR_W] : '0; // R5
         icb_o[ICB_RUN] <= (state_next == ST_DELAY || state_next == ST_RUN || state_next == ST_SUSP); // R7
         icb_o[ICB_SUSPEND] <= (state_next == ST_SUSP);
         icb_o[ICB_GRAD] <= (role_reg == ROLE_GRAD);
         role_o <= role_reg;
         dev_type_o <= dev_s2_reg; // R17
         running_o <= (state_reg == ST_RUN);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_starved; (state_reg == ST_RUN) && tick && !fifo_valid && hold_ok; endsequence
   sequence s_word_kept; $stable(cur_word_reg) && underrun_o ##1 $stable(cur_word_reg); endsequence
   a_underrun_hold: assert property (s_starved |=> s_word_kept) else $error("underrun lost word or flag"); // R21
   a_underrun_sticky: assert property (underrun_o && !underrun_clr_i |=> underrun_o)
      else $error("underrun flag dropped"); // R21
   a_min_hold_time: assert property (pop && role_reg == ROLE_TIMING |=> hold_cnt_reg == 2'(MIN_HOLD_WORDS - 1))
      else $error("hold count wrong"); // R4
   a_link_stays_on: assert property ($past(rstn_i) |-> lnk_en_o) else $error("link driver off"); // R14
   a_balance_lane: assert property (tick |=> sreg_reg[0][6] == ~(^sreg_reg[0][5:0]))
      else $error("balance bit wrong"); // R12
   a_timing_no_data: assert property (role_reg == ROLE_TIMING && tick |=> !lnk_valid_o)
      else $error("link valid in timing role"); // R10
   a_delay_expiry: assert property (state_reg == ST_DELAY && tick && dly_cnt_reg == '0 && !stop_cmd |=> state_reg == ST_RUN)
      else $error("delay expiry missed"); // R6
   a_grad_role_dev: assert property (role_reg == ROLE_GRAD |-> $past(dev_s2_reg) == DEV_GRAD_AMP || state_reg != ST_IDLE)
      else $error("gradient role without amplifier"); // R19
   a_idle_no_start: assert property (state_reg == ST_IDLE && !run_cmd |=> state_reg == ST_IDLE)
      else $error("start without command"); // R9
   a_deskew_on_cmd: assert property (!deskew_busy_o && !deskew_cmd_i |=> !deskew_busy_o)
      else $error("deskew without command"); // R15
endmodule
`default_nettype wire

// [verilog/ppo_pkg.sv]
// constants and types shared by the pulse parameter output channel
`default_nettype none
package ppo_pkg;
   // word and link geometry
   localparam int WORD_W = 48;
   localparam int LANES = 8;
   localparam int LANE_BITS = 6;
   localparam int SLOT_BITS = 7;
   localparam int FWD_HIGH_SLOTS = 4;
   // channel word timing, nanoseconds and rates as documented
   localparam real WORD_PERIOD_NS = 12.5;
   localparam real MIN_HOLD_NS = 25.0;
   localparam int TX_WORD_MHZ = 80;
   localparam int RX_WORD_MHZ = 100;
   localparam int MIN_HOLD_WORDS = int'($ceil(MIN_HOLD_NS / WORD_PERIOD_NS));
   // output delay reaches two to the 29th word cycles
   localparam int DELAY_W = 30;
   localparam int FIFO_DEPTH = 32;
   // gradient word layout: 1k channel addresses in the top bits
   localparam int GRAD_ADDR_W = 10;
   localparam int GRAD_ADDR_LSB = 38;
   // deskew training
   localparam int DESKEW_WORDS = 16;
   localparam logic [47:0] DESKEW_PATTERN = 48'h5555_aaaa_5555;
   localparam logic [47:0] IDLE_WORD = 48'h0000_0000_0000;
   // inter-channel bus bit positions
   localparam int ICB_W = 3;
   localparam int ICB_RUN = 0;
   localparam int ICB_SUSPEND = 1;
   localparam int ICB_GRAD = 2;
   // attached-device codes on the status lines
   localparam logic [1:0] DEV_NONE = 2'h0;
   localparam logic [1:0] DEV_FREQ_GEN = 2'h1;
   localparam logic [1:0] DEV_GRAD_AMP = 2'h2;
   localparam logic [1:0] DEV_PREEMPH = 2'h3;
   typedef enum logic [1:0] {
      ROLE_FREQ = 2'b00,
      ROLE_GRAD = 2'b01,
      ROLE_TIMING = 2'b10
   } ppo_role_type;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DELAY = 2'b01,
      ST_RUN = 2'b10,
      ST_SUSP = 2'b11
   } ppo_state_type;
endpackage
`default_nettype wire
